// >>> rtl/bq4_pkg.sv
// Package of constants, types and helpers for the burst-of-four SRAM command block
package bq4_pkg;

	// Array geometry and burst shape
	localparam int ADDR_W = 10;
	localparam int DATA_W = 18;
	localparam int BEAT_W = 2;
	localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_SECOND = 2'h1;
	localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;

	// Reference clock and clock-stop detection (least time, rounded up)
	localparam int T_REF_NS = 10;
	localparam int T_CLK_STOP_NS = 30;
	localparam int CLK_STOP_CYC = (T_CLK_STOP_NS + T_REF_NS - 1) / T_REF_NS;
	localparam int STOP_W = 3;
	localparam logic [STOP_W-1:0] STOP_ZERO = 3'h0;
	localparam logic [STOP_W-1:0] STOP_ONE = 3'h1;
	localparam logic [STOP_W-1:0] STOP_CNT = STOP_W'(CLK_STOP_CYC);

	// Least low time of the DLL-disable pin before its rise resets the DLL
	localparam int DLL_DISABLE_LOW_MIN_TIME_NS = 100;
	localparam int DIS_LOW_CYC = (DLL_DISABLE_LOW_MIN_TIME_NS + T_REF_NS - 1) / T_REF_NS;
	localparam int LOW_W = 8;
	localparam logic [LOW_W-1:0] LOW_ZERO = 8'h00;
	localparam logic [LOW_W-1:0] LOW_ONE = 8'h01;
	localparam logic [LOW_W-1:0] LOW_CNT = LOW_W'(DIS_LOW_CYC);

	// DLL lock interval in rising edges of the main input clock
	localparam int DLL_LOCK_INTERVAL = 2048;
	localparam int LOCK_W = 11;
	localparam logic [LOCK_W-1:0] LOCK_ZERO = 11'h000;
	localparam logic [LOCK_W-1:0] LOCK_ONE = 11'h001;
	localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(DLL_LOCK_INTERVAL - 1);

	// Latencies in half-cycles (input clock edges) from the command edge
	localparam int PIPE_DEPTH = 5;
	localparam int RD_LAT_DLL = 5;
	localparam int RD_LAT_BYPASS = 2;
	localparam int WR_LAT = 2;

	// Lock/initialisation state
	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_LOCKED = 2'b01,
		ST_BYPASS = 2'b10
	} bq4_state_t;

	// Pins as seen after synchronisation
	typedef struct packed {
		logic k;
		logic kn;
		logic dis_n;
		logic load_n;
		logic rw;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
	} bq4_pins_t;

	// One queued command in a latency pipe
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
	} bq4_cmd_t;

	localparam bq4_cmd_t CMD_NONE = '{valid: 1'b0, addr: '0};

	// Linear burst address: base plus beat number
	function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
		input logic [BEAT_W-1:0] beat);
		burst_addr = base + ADDR_W'(beat);
	endfunction : burst_addr

endpackage : bq4_pkg

// >>> rtl/bq4_burst_ram.sv
// Storage array behind the burst engine: one write port, one combinational read port
`timescale 1ns/1ns
`default_nettype none

module bq4_burst_ram (
	input wire logic clk, // Reference clock
	input wire logic wr_en, // Write one beat
	input wire logic [bq4_pkg::ADDR_W-1:0] wr_addr, // Beat address to write
	input wire logic [bq4_pkg::DATA_W-1:0] wr_data, // Beat data to write
	input wire logic [bq4_pkg::ADDR_W-1:0] rd_addr, // Beat address to read
	output logic [bq4_pkg::DATA_W-1:0] rd_data // Read data, old value on a same-cycle write
);

	logic [bq4_pkg::DATA_W-1:0] mem [0:(1 << bq4_pkg::ADDR_W)-1];

	////////////////////////////////////////////////////////////////////////////////
	// Write port, no reset: contents are undefined after power-up
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read port
	assign rd_data = mem[rd_addr];

endmodule : bq4_burst_ram

`default_nettype wire

// >>> rtl/bq4_ctrl.sv
// Burst-of-four DDR SRAM command, burst and DLL lock/init block
// Notes on behaviour
// - A DLL-disable release before clocks are stable needs a later DLL reset, then re-lock.
// - Either input clock static for more than 30 ns resets the DLL for re-lock.
// - After a DLL reset the device locks over the lock interval before normal use.
// - A rise of the DLL-disable pin after its least low time resets the DLL.
// - The burst counter walks base, base+1, base+2, base+3.
// - Load strobe low and read/write select high at a K rise is a read.
// - Load strobe low and read/write select low at a K rise is a write.
// - Load strobe high at a K rise is a no-operation with the bus undriven for all beats.
// - Pending bursts finish before a clock stop; outputs hold while clocks stand still.
// - Read beats leave on K# at t+2.5, K at t+3.0, K# at t+3.5 and K at t+4.0.
// - A DLL-disable release after stable clocks and the least low time leads to lock within the interval.
// - With the DLL-disable pin low the DLL is bypassed and read latency is one cycle.
// - DLL lock is reached within 2048 stable input clock cycles after a DLL reset.
`timescale 1ns/1ns
`default_nettype none

module bq4_ctrl (
	input wire logic REF_CLK, // 100 MHz sampling clock
	input wire logic SRST, // Synchronous reset, active high
	input wire logic K_CLK, // Main input clock pin
	input wire logic K_CLK_N, // Complementary input clock pin
	input wire logic DLL_DISABLE_N, // Low bypasses the DLL
	input wire logic LOAD_STROBE_N, // Command load, active low
	input wire logic RW_SEL, // High read, low write
	input wire logic [bq4_pkg::ADDR_W-1:0] ADDR, // Burst base address
	input wire logic [bq4_pkg::DATA_W-1:0] DQ_I, // Data bus, incoming level
	output logic [bq4_pkg::DATA_W-1:0] DQ_O, // Data bus, driven value
	output logic DQ_OE, // High while driving the data bus
	output logic DEV_READY, // Lock interval over, ready for use
	output logic DLL_LOCKED // DLL locked and in use
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge history
	bq4_pkg::bq4_pins_t pins_s1_r;
	bq4_pkg::bq4_pins_t pins_s2_r;
	logic k_d_r;
	logic kn_d_r;
	logic k_rise;
	logic kn_rise;
	logic half_edge;

	// Every pin passes two flops; edge history reads the second stage only
	always_ff @(posedge REF_CLK)
	begin
		pins_s1_r <= '{k: K_CLK, kn: K_CLK_N, dis_n: DLL_DISABLE_N, load_n: LOAD_STROBE_N,
			rw: RW_SEL, addr: ADDR, dq: DQ_I};
		pins_s2_r <= pins_s1_r;
		k_d_r <= pins_s2_r.k;
		kn_d_r <= pins_s2_r.kn;
	end

	// Each rising edge of K or K# is one half-cycle step of the burst engine
	assign k_rise = pins_s2_r.k & ~k_d_r;
	assign kn_rise = pins_s2_r.kn & ~kn_d_r;
	assign half_edge = k_rise | kn_rise;

	////////////////////////////////////////////////////////////////////////////////
	// Clock-stop and DLL-disable monitors, lock interval counter, state
	logic [bq4_pkg::STOP_W-1:0] stop_k_r, stop_k_nxt;
	logic [bq4_pkg::STOP_W-1:0] stop_kn_r, stop_kn_nxt;
	logic [bq4_pkg::LOW_W-1:0] low_r, low_nxt;
	logic dis_d_r, dis_d_nxt;
	logic [bq4_pkg::LOCK_W-1:0] lock_r, lock_nxt;
	bq4_pkg::bq4_state_t st_r, st_nxt;
	logic stop_evt;
	logic toggle_evt;
	logic dll_rst;

	// Counts of reference cycles for which a clock level has not moved
	function automatic logic [bq4_pkg::STOP_W-1:0] stop_step(input logic lvl, input logic prev,
		input logic [bq4_pkg::STOP_W-1:0] cnt);
		if (lvl != prev)
			stop_step = bq4_pkg::STOP_ZERO;
		else if (cnt != bq4_pkg::STOP_CNT)
			stop_step = cnt + bq4_pkg::STOP_ONE;
		else
			stop_step = cnt;
	endfunction : stop_step

	always_comb
	begin
		stop_k_nxt = stop_step(pins_s2_r.k, k_d_r, stop_k_r);
		stop_kn_nxt = stop_step(pins_s2_r.kn, kn_d_r, stop_kn_r);
		// One pulse as either clock first counts as stopped: level held past 30 ns
		stop_evt = (stop_k_nxt == bq4_pkg::STOP_CNT && stop_k_r != bq4_pkg::STOP_CNT) ||
			(stop_kn_nxt == bq4_pkg::STOP_CNT && stop_kn_r != bq4_pkg::STOP_CNT);
		// Low time saturates; a rise resets the DLL only after the least low time
		low_nxt = pins_s2_r.dis_n ? bq4_pkg::LOW_ZERO :
			(low_r == bq4_pkg::LOW_CNT) ? low_r : low_r + bq4_pkg::LOW_ONE;
		dis_d_nxt = pins_s2_r.dis_n;
		toggle_evt = pins_s2_r.dis_n && !dis_d_r && (low_r == bq4_pkg::LOW_CNT);
		// Either reset sequence also serves a frequency change
		dll_rst = stop_evt | toggle_evt;
		lock_nxt = lock_r;
		st_nxt = st_r;
		case (st_r)
			bq4_pkg::ST_INIT:
			begin
				// Lock interval is counted on stable K rises only
				if (k_rise)
				begin
					lock_nxt = lock_r + bq4_pkg::LOCK_ONE;
					if (lock_r == bq4_pkg::LOCK_LAST)
					begin
						st_nxt = pins_s2_r.dis_n ? bq4_pkg::ST_LOCKED : bq4_pkg::ST_BYPASS;
					end
				end
			end
			bq4_pkg::ST_LOCKED:
			begin
				if (!pins_s2_r.dis_n)
				begin
					st_nxt = bq4_pkg::ST_BYPASS;
				end
			end
			bq4_pkg::ST_BYPASS:
			begin
				st_nxt = bq4_pkg::ST_BYPASS; // A short pin pulse leaves the DLL unlocked
			end
			default:
			begin
				st_nxt = bq4_pkg::ST_INIT;
			end
		endcase
		// A reset event restarts the lock interval from any state
		if (dll_rst)
		begin
			st_nxt = bq4_pkg::ST_INIT;
			lock_nxt = bq4_pkg::LOCK_ZERO;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			stop_k_r <= bq4_pkg::STOP_ZERO;
			stop_kn_r <= bq4_pkg::STOP_ZERO;
			low_r <= bq4_pkg::LOW_ZERO;
			dis_d_r <= 1'b0;
			lock_r <= bq4_pkg::LOCK_ZERO;
			st_r <= bq4_pkg::ST_INIT;
		end
		else
		begin
			stop_k_r <= stop_k_nxt;
			stop_kn_r <= stop_kn_nxt;
			low_r <= low_nxt;
			dis_d_r <= dis_d_nxt;
			lock_r <= lock_nxt;
			st_r <= st_nxt;
		end
	end

	assign DEV_READY = (st_r != bq4_pkg::ST_INIT);
	assign DLL_LOCKED = (st_r == bq4_pkg::ST_LOCKED);

	////////////////////////////////////////////////////////////////////////////////
	// Command decode and half-cycle latency pipes
	bq4_pkg::bq4_cmd_t rd_pipe_r [0:bq4_pkg::PIPE_DEPTH-1];
	bq4_pkg::bq4_cmd_t rd_pipe_nxt [0:bq4_pkg::PIPE_DEPTH-1];
	bq4_pkg::bq4_cmd_t wr_pipe_r [0:bq4_pkg::PIPE_DEPTH-1];
	bq4_pkg::bq4_cmd_t wr_pipe_nxt [0:bq4_pkg::PIPE_DEPTH-1];
	logic busy_r, busy_nxt;
	logic cmd_take;
	logic bypass;

	// A burst spans two K cycles, so the K rise after a taken command is ignored
	always_comb
	begin
		cmd_take = k_rise && !pins_s2_r.load_n && !busy_r; // Load high is a no-op
		busy_nxt = k_rise ? cmd_take : busy_r;
		for (int i = 0; i < bq4_pkg::PIPE_DEPTH; i++)
		begin
			rd_pipe_nxt[i] = rd_pipe_r[i];
			wr_pipe_nxt[i] = wr_pipe_r[i];
		end
		if (half_edge)
		begin
			rd_pipe_nxt[0] = bq4_pkg::CMD_NONE;
			wr_pipe_nxt[0] = bq4_pkg::CMD_NONE;
			if (cmd_take && pins_s2_r.rw)
				rd_pipe_nxt[0] = '{valid: 1'b1, addr: pins_s2_r.addr};
			if (cmd_take && !pins_s2_r.rw)
				wr_pipe_nxt[0] = '{valid: 1'b1, addr: pins_s2_r.addr};
			for (int i = 1; i < bq4_pkg::PIPE_DEPTH; i++)
			begin
				rd_pipe_nxt[i] = rd_pipe_r[i-1];
				wr_pipe_nxt[i] = wr_pipe_r[i-1];
			end
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			busy_r <= 1'b0;
			for (int i = 0; i < bq4_pkg::PIPE_DEPTH; i++)
			begin
				rd_pipe_r[i] <= bq4_pkg::CMD_NONE;
				wr_pipe_r[i] <= bq4_pkg::CMD_NONE;
			end
		end
		else
		begin
			busy_r <= busy_nxt;
			for (int i = 0; i < bq4_pkg::PIPE_DEPTH; i++)
			begin
				rd_pipe_r[i] <= rd_pipe_nxt[i];
				wr_pipe_r[i] <= wr_pipe_nxt[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Burst engines and data bus
	logic rd_act_r, rd_act_nxt;
	logic [bq4_pkg::ADDR_W-1:0] rd_base_r, rd_base_nxt;
	logic [bq4_pkg::BEAT_W-1:0] rd_idx_r, rd_idx_nxt;
	logic wr_act_r, wr_act_nxt;
	logic [bq4_pkg::ADDR_W-1:0] wr_base_r, wr_base_nxt;
	logic [bq4_pkg::BEAT_W-1:0] wr_idx_r, wr_idx_nxt;
	logic [bq4_pkg::DATA_W-1:0] dq_o_r, dq_o_nxt;
	logic dq_oe_r, dq_oe_nxt;
	bq4_pkg::bq4_cmd_t rd_start;
	bq4_pkg::bq4_cmd_t wr_start;
	logic [bq4_pkg::ADDR_W-1:0] rd_addr;
	logic [bq4_pkg::ADDR_W-1:0] wr_addr;
	logic [bq4_pkg::DATA_W-1:0] rd_data;
	logic wr_en;

	// Read latency follows the DLL: 2.5 cycles locked, one cycle bypassed
	assign bypass = (st_r == bq4_pkg::ST_BYPASS) || !pins_s2_r.dis_n;

	always_comb
	begin
		rd_start = bypass ? rd_pipe_r[bq4_pkg::RD_LAT_BYPASS-1] :
			rd_pipe_r[bq4_pkg::RD_LAT_DLL-1];
		wr_start = wr_pipe_r[bq4_pkg::WR_LAT-1];
		rd_addr = rd_start.valid ? rd_start.addr : bq4_pkg::burst_addr(rd_base_r, rd_idx_r);
		wr_addr = wr_start.valid ? wr_start.addr : bq4_pkg::burst_addr(wr_base_r, wr_idx_r);
		wr_en = half_edge && (wr_start.valid || wr_act_r);
		rd_act_nxt = rd_act_r;
		rd_base_nxt = rd_base_r;
		rd_idx_nxt = rd_idx_r;
		wr_act_nxt = wr_act_r;
		wr_base_nxt = wr_base_r;
		wr_idx_nxt = wr_idx_r;
		// Bus only changes on clock edges, so it holds while the clocks stop
		dq_o_nxt = dq_o_r;
		dq_oe_nxt = dq_oe_r;
		if (half_edge)
		begin
			if (rd_start.valid)
			begin
				rd_act_nxt = 1'b1;
				rd_base_nxt = rd_start.addr;
				rd_idx_nxt = bq4_pkg::BEAT_SECOND;
			end
			else if (rd_act_r)
			begin
				rd_idx_nxt = rd_idx_r + bq4_pkg::BEAT_SECOND;
				rd_act_nxt = (rd_idx_r != bq4_pkg::BEAT_LAST);
			end
			if (wr_start.valid)
			begin
				wr_act_nxt = 1'b1;
				wr_base_nxt = wr_start.addr;
				wr_idx_nxt = bq4_pkg::BEAT_SECOND;
			end
			else if (wr_act_r)
			begin
				wr_idx_nxt = wr_idx_r + bq4_pkg::BEAT_SECOND;
				wr_act_nxt = (wr_idx_r != bq4_pkg::BEAT_LAST);
			end
			// One beat per edge; without a read beat the bus is released
			dq_oe_nxt = rd_start.valid || rd_act_r;
			if (dq_oe_nxt)
				dq_o_nxt = rd_data;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			rd_act_r <= 1'b0;
			rd_base_r <= '0;
			rd_idx_r <= bq4_pkg::BEAT_FIRST;
			wr_act_r <= 1'b0;
			wr_base_r <= '0;
			wr_idx_r <= bq4_pkg::BEAT_FIRST;
			dq_o_r <= '0;
			dq_oe_r <= 1'b0;
		end
		else
		begin
			rd_act_r <= rd_act_nxt;
			rd_base_r <= rd_base_nxt;
			rd_idx_r <= rd_idx_nxt;
			wr_act_r <= wr_act_nxt;
			wr_base_r <= wr_base_nxt;
			wr_idx_r <= wr_idx_nxt;
			dq_o_r <= dq_o_nxt;
			dq_oe_r <= dq_oe_nxt;
		end
	end

	assign DQ_O = dq_o_r;
	assign DQ_OE = dq_oe_r;

	// Array; a read on the same edge as a write to its address sees the old data
	bq4_burst_ram u_ram (
		.clk(REF_CLK),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(pins_s2_r.dq),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

endmodule : bq4_ctrl

`default_nettype wire

// >>> tb/bq4_ctrl_checker.sv
// Port checker for the burst-of-four command block
`timescale 1ns/1ns
`default_nettype none

module bq4_ctrl_checker (
	input wire logic REF_CLK, // Sampling clock
	input wire logic SRST, // Synchronous reset
	input wire logic K_CLK, // Main input clock
	input wire logic DLL_DISABLE_N, // DLL-disable pin
	input wire logic LOAD_STROBE_N, // Command load
	input wire logic RW_SEL, // Read or write
	input wire logic [bq4_pkg::DATA_W-1:0] DQ_O, // Drive value
	input wire logic DQ_OE, // Drive enable
	input wire logic DEV_READY, // Ready flag
	input wire logic DLL_LOCKED // Lock flag
);
	logic k_r;
	logic dis_r;
	logic k_rise;
	logic [2:0] stop_r;
	logic [2:0] stop_nxt;
	logic [11:0] kcnt_r;
	logic [11:0] kcnt_nxt;
	logic [4:0] age_r;
	logic [4:0] age_nxt;

	// K rises since the last DLL reset, and cycles since the last read command
	always_comb
	begin
		k_rise = K_CLK && !k_r;
		stop_nxt = (SRST || K_CLK != k_r) ? 3'h0 : stop_r + {2'h0, stop_r != 3'h7};
		kcnt_nxt = kcnt_r + {11'h000, k_rise};
		// The first rise after a clock stop already counts toward the lock interval
		if (SRST || (stop_r >= 3'h2 && !k_rise) || (DLL_DISABLE_N && !dis_r))
			kcnt_nxt = 12'h000;
		age_nxt = age_r + {4'h0, age_r != 5'h1f};
		if (SRST)
			age_nxt = 5'h1f;
		else if (k_rise && !LOAD_STROBE_N && RW_SEL)
			age_nxt = 5'h00;
	end

	// Helper registers only
	always_ff @(posedge REF_CLK)
	begin
		k_r <= K_CLK;
		dis_r <= DLL_DISABLE_N;
		stop_r <= stop_nxt;
		kcnt_r <= kcnt_nxt;
		age_r <= age_nxt;
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);

	ready_after_lock_a: assert property (DLL_LOCKED |-> DEV_READY)
		else $error("locked flag without ready flag");
	reset_quiet_a: assert property ($past(SRST) |-> !DEV_READY && !DQ_OE)
		else $error("ready or drive right after reset");
	clock_stop_a: assert property ($stable(K_CLK) [*8] |-> ##[0:3] !DEV_READY)
		else $error("clock stop did not reset the DLL");
	lock_count_a: assert property ($rose(DEV_READY) |-> kcnt_r == 12'h800)
		else $error("ready after wrong number of K rises");
	lock_mode_a: assert property ($rose(DEV_READY) |-> DLL_LOCKED == DLL_DISABLE_N)
		else $error("lock state does not follow the disable pin");
	bypass_low_a: assert property (!DLL_DISABLE_N [*6] |-> !DLL_LOCKED)
		else $error("DLL in use while disabled");
	read_delay_a: assert property ($rose(DQ_OE) |-> (DLL_LOCKED ?
		age_r inside {[11:14]} : age_r inside {[5:8]})) else $error("read beat at wrong edge");
	burst_len_a: assert property ($rose(DQ_OE) |-> DQ_OE [*8] ##1 !DQ_OE)
		else $error("read burst not four beats");
	// A read taken at this very rise answers within 8 cycles when bypassed, so it is left out
	idle_quiet_a: assert property ($rose(K_CLK) && age_r == 5'h1f &&
		(LOAD_STROBE_N || !RW_SEL) |-> !DQ_OE [*8]) else $error("bus driven without a read");
	stop_hold_a: assert property ($stable(K_CLK) [*5] |-> $stable(DQ_O) && $stable(DQ_OE))
		else $error("outputs moved while clocks stood");

	cover property ($rose(DQ_OE) && DLL_LOCKED);
	cover property ($rose(DQ_OE) && !DLL_LOCKED);
	cover property ($rose(DEV_READY));
	cover property ($stable(K_CLK) [*8]);
endmodule : bq4_ctrl_checker

bind bq4_ctrl bq4_ctrl_checker chk (.REF_CLK, .SRST, .K_CLK, .DLL_DISABLE_N, .LOAD_STROBE_N,
	.RW_SEL, .DQ_O, .DQ_OE, .DEV_READY, .DLL_LOCKED);

`default_nettype wire

// >>> tb/bq4_host_model.sv
// Memory-controller model driving the pins of the burst-of-four command block
`timescale 1ns/1ns
`default_nettype none

module bq4_host_model (
	input wire logic clk, // Reference clock
	input wire logic [bq4_pkg::DATA_W-1:0] dev_q, // Device data
	input wire logic dev_oe, // Device drives the bus
	output logic k, // Main input clock
	output logic kn, // Complementary input clock
	output logic dis_n, // DLL-disable pin
	output logic load_n, // Command load, active low
	output logic rw, // High read, low write
	output logic [bq4_pkg::ADDR_W-1:0] addr, // Burst base address
	output logic [bq4_pkg::DATA_W-1:0] bus // Level on the shared data bus
);
	logic run = 1'b0;
	logic ph = 1'b0;
	logic drv_en = 1'b0;
	logic [bq4_pkg::DATA_W-1:0] drv = 18'h00000;
	logic [bq4_pkg::DATA_W-1:0] last = 18'h00000;

	// Defined levels from time zero, DLL held disabled until clocks settle
	initial
	begin
		k = 1'b0;
		dis_n = 1'b0;
		load_n = 1'b1;
		rw = 1'b0;
		addr = 10'h000;
	end

	// Clocks toggle every second cycle; stopping is only done between bursts
	always @(negedge clk)
	begin
		if (run)
		begin
			ph <= !ph;
			if (ph)
				k <= !k;
		end
		last <= bus;
	end
	assign kn = !k;

	// Released bus shows a pattern that flips every cycle, never a stale value
	assign bus = dev_oe ? dev_q : (drv_en ? drv : ~last);

	// Command set up after a K fall and held through the next K rise
	task automatic cmd(input logic r, input logic [bq4_pkg::ADDR_W-1:0] a);
		@(negedge k);
		load_n = 1'b0;
		rw = r;
		addr = a;
		@(negedge k);
		load_n = 1'b1;
		rw = !r;
		addr = ~a;
	endtask : cmd

	// Late write: beats centred on the K, K#, K, K# edges after the command
	task automatic wr(input logic [bq4_pkg::ADDR_W-1:0] a, input logic [3:0][17:0] d);
		cmd(1'b0, a);
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk);
			drv = d[i];
			drv_en = 1'b1;
			@(k);
		end
		@(negedge clk);
		drv_en = 1'b0;
	endtask : wr
endmodule : bq4_host_model

`default_nettype wire

// >>> tb/bq4_ctrl_bench.sv
// Self-checking bench for the burst-of-four command block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
	$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end

module bq4_ctrl_bench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	int compares = 0;
	int n_mismatch = 0;
	logic k;
	logic kn;
	logic dis_n;
	logic load_n;
	logic rw;
	logic [bq4_pkg::ADDR_W-1:0] addr;
	logic [bq4_pkg::DATA_W-1:0] bus;
	logic [bq4_pkg::DATA_W-1:0] dev_q;
	logic dev_oe;
	logic ready;
	logic locked;

	bq4_host_model host (.clk, .dev_q, .dev_oe, .k, .kn, .dis_n, .load_n, .rw, .addr, .bus);
	bq4_ctrl dut (.REF_CLK(clk), .SRST(srst), .K_CLK(k), .K_CLK_N(kn), .DLL_DISABLE_N(dis_n),
		.LOAD_STROBE_N(load_n), .RW_SEL(rw), .ADDR(addr), .DQ_I(bus), .DQ_O(dev_q),
		.DQ_OE(dev_oe), .DEV_READY(ready), .DLL_LOCKED(locked));

	// 100 MHz reference clock
	always #5 clk = ~clk;

	// Stored data is a function of its address, so any beat can be predicted
	function automatic logic [17:0] pat(input logic [9:0] a);
		pat = {8'h6c, a};
	endfunction : pat

	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// No traffic until a full lock interval has passed
	task automatic t_lock(input logic lk);
		repeat (2047) @(posedge k);
		`CHK(ready, 1'b0)
		repeat (2) @(posedge k);
		`CHK(ready, 1'b1)
		`CHK(locked, lk)
	endtask : t_lock

	task automatic t_wr(input logic [9:0] b);
		logic [3:0][17:0] d;
		for (int i = 0; i < 4; i++)
			d[i] = pat(b + 10'(i));
		host.wr(b, d);
	endtask : t_wr

	// Beat n is looked at two edges after the edge that launches it
	task automatic t_read(input logic [9:0] a, input int lat);
		host.cmd(1'b1, a);
		repeat (lat) @(k);
		`CHK(dev_oe, 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			@(k);
			`CHK(dev_oe, 1'b1)
			`CHK(dev_q, pat(a + 10'(i)))
		end
		@(k);
		`CHK(dev_oe, 1'b0)
	endtask : t_read

	task automatic t_power;
		host.run = 1'b1;
		repeat (10) @(posedge k);
		host.dis_n = 1'b1;
		t_lock(1'b1);
		$display("power-up done");
	endtask : t_power

	// Write and read bursts, one of each wrapping past the top of the array
	task automatic t_data;
		t_wr(10'h002);
		t_wr(10'h3fe);
		t_read(10'h000, 5);
		t_read(10'h3fe, 5);
		$display("write and read done");
	endtask : t_data

	// Read select high with load high: a decoder that ignored the load strobe would read
	task automatic t_nop;
		host.rw = 1'b1;
		repeat (12)
		begin
			@(k);
			`CHK(dev_oe, 1'b0)
		end
		$display("no-operation done");
	endtask : t_nop

	task automatic t_stop;
		@(negedge k);
		host.run = 1'b0;
		repeat (10) @(negedge clk);
		`CHK(dev_q, pat(10'h001))
		`CHK(ready, 1'b0)
		host.run = 1'b1;
		t_lock(1'b1);
		$display("clock stop done");
	endtask : t_stop

	task automatic t_bypass;
		@(negedge clk);
		host.dis_n = 1'b0;
		repeat (8) @(negedge clk);
		`CHK(locked, 1'b0)
		`CHK(ready, 1'b1)
		t_read(10'h3fe, 2);
		@(posedge k);
		host.dis_n = 1'b1;
		t_lock(1'b1);
		host.dis_n = 1'b0;
		repeat (5) @(negedge clk);
		host.dis_n = 1'b1;
		repeat (8) @(negedge clk);
		`CHK(locked, 1'b0)
		`CHK(ready, 1'b1)
		$display("bypass done");
	endtask : t_bypass

	// Mid-run reset while ready: flags drop, and ready stays down after release
	task automatic t_reset;
		@(negedge clk);
		srst = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(ready, 1'b0)
		`CHK(locked, 1'b0)
		`CHK(dev_oe, 1'b0)
		srst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(ready, 1'b0)
		`CHK(dev_oe, 1'b0)
		$display("reset done");
	endtask : t_reset

	// Main sequence
	initial
	begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		t_power();
		t_data();
		t_nop();
		t_stop();
		t_bypass();
		t_reset();
		end_sim();
	end

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end
endmodule : bq4_ctrl_bench

`default_nettype wire
